// ===== fsl_pkg.sv
// Shared constants and types for the fan stop, soft-switch and lock controller
package fsl_pkg;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          LOCK_DET_MS     = 300;
  localparam int          LOCK_SHORT_MS   = 3500;
  localparam int          LOCK_LONG_MS    = 14000;
  localparam int          LOCK_DET_CYC    = CLK_HZ / 1000 * LOCK_DET_MS;
  localparam longint      LOCK_SHORT_CYCL = longint'(CLK_HZ) / 1000 * LOCK_SHORT_MS;
  localparam longint      LOCK_LONG_CYCL  = longint'(CLK_HZ) / 1000 * LOCK_LONG_MS;
  localparam logic [2:0]  LOCK_SHORT_RUNS = 3'h4;
  localparam logic [2:0]  RESTART_EDGES   = 3'h4;
  localparam logic [7:0]  STOP_STEP       = 8'h05;
  localparam logic [3:0]  STOP_USE_MIN    = 4'hf;
  // 1.6 % of a 0..255 duty scale is about 4 counts
  localparam logic [7:0]  STOP_HYST       = 8'h04;
  // Soft-switch fraction is (code+1)*15/512 of one commutation period
  localparam logic [4:0]  SSW_NUM         = 5'h0f;
  localparam int          SSW_SHIFT       = 9;
  localparam logic [7:0]  PHASE_MAG_MAX   = 8'h7f;
  localparam logic [7:0]  DUTY_FULL       = 8'hff;
  localparam logic [1:0]  DRV_LOW_SIDE    = 2'h0;

  typedef enum logic [3:0] {
    FSL_STOPPED = 4'b0001,
    FSL_RUN     = 4'b0010,
    FSL_LOCKED  = 4'b0100,
    FSL_RESTART = 4'b1000
  } fsl_state_t;
endpackage

// ===== fsl_ctrl.sv
// Fan driver control: low-duty stop, soft switch, tach, phase adjust, protections
`timescale 1ns/10ps
module fsl_ctrl #(
  parameter longint LOCK_SHORT_CYC = fsl_pkg::LOCK_SHORT_CYCL,
  parameter longint LOCK_LONG_CYC  = fsl_pkg::LOCK_LONG_CYCL,
  parameter int     LOCK_DET      = fsl_pkg::LOCK_DET_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_duty_in,
  input  wire logic       i_pwm_edge,
  input  wire logic [7:0] i_duty_min,
  input  wire logic [7:0] i_duty_max,
  input  wire logic [7:0] i_speed_min,
  input  wire logic [7:0] i_speed_max,
  input  wire logic [3:0] i_stop_select,
  input  wire logic       i_full_output,
  input  wire logic [3:0] i_softswitch_width_fast,
  input  wire logic [3:0] i_softswitch_width_slow,
  input  wire logic [7:0] i_phase_adjust_fast,
  input  wire logic [7:0] i_phase_adjust_slow,
  input  wire logic [7:0] i_loop_duty,
  input  wire logic [15:0] i_comm_period,
  input  wire logic       i_tach_output_select,
  input  wire logic [1:0] i_drive_mode_select,
  input  wire logic       i_hall_input_a,
  input  wire logic       i_hall_input_b,
  input  wire logic       i_thermal_shutdown,
  input  wire logic       i_undervoltage_lockout,
  input  wire logic       i_current_limiter,
  output logic [7:0]      o_target_speed,
  output logic            o_full_drive,
  output logic [8:0]      o_phase_adjust,
  output logic [7:0]      o_out_duty,
  output logic            o_bridge_out_a,
  output logic            o_bridge_out_a_oe,
  output logic            o_bridge_out_b,
  output logic            o_bridge_out_b_oe,
  output logic            o_recirculate,
  output logic            o_tach_pulse_out,
  output logic            o_lock_active
);
  import fsl_pkg::*;

  // Linear interpolation of y between (x0,y0) and (x1,y1), not clamped to x range
  function automatic logic [7:0] lerp8(input logic [7:0] x, input logic [7:0] x0,
                                       input logic [7:0] x1, input logic [7:0] y0,
                                       input logic [7:0] y1);
    logic signed [17:0] num;
    logic        [7:0]  span;
    num  = 18'(signed'({1'b0, y1}) - signed'({1'b0, y0})) * 18'(signed'({1'b0, x - x0}));
    span = (x1 > x0) ? (x1 - x0) : 8'h01;
    lerp8 = 8'(18'(signed'({10'h000, y0})) + num / 18'(signed'({10'h000, span})));
  endfunction

  // ------------------------------------------------------------
  // Duty to speed policy
  // ------------------------------------------------------------
  logic [7:0] stop_thr;
  logic [7:0] code_thr;
  logic       stopped_low;
  logic       zero_duty;
  always_comb begin
    code_thr = 8'(STOP_STEP * i_stop_select);
    if (i_stop_select == STOP_USE_MIN || i_duty_min < code_thr)
      stop_thr = i_duty_min;
    else
      stop_thr = code_thr;
  end
  // Duty at or below the threshold counts as zero-speed; code 0 never does
  assign zero_duty = (i_stop_select != 4'h0) && (i_duty_in <= stop_thr);

  always_ff @(posedge i_clk) begin
    if (i_rst)
      stopped_low <= 1'b1;
    else if (zero_duty)
      stopped_low <= 1'b1;
    else if (i_duty_in > 8'(stop_thr + STOP_HYST) || i_stop_select == 4'h0)
      stopped_low <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_target_speed <= 8'h00;
      o_full_drive   <= 1'b0;
    end else if (stopped_low) begin
      o_target_speed <= 8'h00;
      o_full_drive   <= 1'b0;
    end else if (i_duty_in < i_duty_min) begin
      o_target_speed <= i_speed_min;
      o_full_drive   <= 1'b0;
    end else if (i_duty_in > i_duty_max) begin
      o_target_speed <= i_speed_max;
      o_full_drive   <= i_full_output;
    end else begin
      o_target_speed <= lerp8(i_duty_in, i_duty_min, i_duty_max,
                              i_speed_min, i_speed_max);
      o_full_drive   <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Phase adjust, signed degrees in 22.225/127 steps
  // ------------------------------------------------------------
  logic signed [8:0] ph_fast;
  logic signed [8:0] ph_slow;
  logic signed [19:0] ph_num;
  logic        [7:0]  spd_span;
  // MSB selects direction, low bits the magnitude in steps
  assign ph_fast = i_phase_adjust_fast[7] ? 9'(i_phase_adjust_fast[6:0])
                                          : -9'(i_phase_adjust_fast[6:0]);
  assign ph_slow = i_phase_adjust_slow[7] ? 9'(i_phase_adjust_slow[6:0])
                                          : -9'(i_phase_adjust_slow[6:0]);
  assign spd_span = (i_speed_max > i_speed_min) ? (i_speed_max - i_speed_min) : 8'h01;
  // Not clamped to the speed range, so it extrapolates when the target speed is zero at stop
  assign ph_num = 20'(ph_fast - ph_slow) *
                  20'(signed'({1'b0, o_target_speed}) - signed'({1'b0, i_speed_min}));
  always_ff @(posedge i_clk) begin
    if (i_rst)
      o_phase_adjust <= 9'h000;
    else
      o_phase_adjust <= 9'(20'(ph_slow) + ph_num / 20'(signed'({12'h000, spd_span})));
  end

  // ------------------------------------------------------------
  // Hall crossing, tach and soft switch ramp
  // ------------------------------------------------------------
  logic       hall_q;
  logic       hall_cross;
  logic [3:0] ssw_code;
  logic [15:0] ramp_len;
  logic [15:0] since_comm;
  logic        tach_toggle;
  logic [7:0]  ramp_duty;
  assign hall_cross = (i_hall_input_a != hall_q);
  assign ssw_code = 4'(lerp8(o_target_speed, i_speed_min, i_speed_max,
                             {4'h0, i_softswitch_width_slow},
                             {4'h0, i_softswitch_width_fast}));
  assign ramp_len = 16'((32'(i_comm_period) * 32'(SSW_NUM) * (32'(ssw_code) + 32'h1))
                        >> SSW_SHIFT);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hall_q      <= 1'b0;
      since_comm  <= 16'h0000;
      tach_toggle <= 1'b0;
    end else begin
      hall_q <= i_hall_input_a;
      if (hall_cross) begin
        tach_toggle <= ~tach_toggle;
        since_comm  <= 16'h0000;
      end else if (since_comm != 16'hffff) begin
        since_comm <= since_comm + 16'h0001;
      end
    end
  end

  // Ramp up after the change, down ahead of the expected next change
  always_comb begin
    logic [15:0] left;
    left = (i_comm_period > since_comm) ? (i_comm_period - since_comm) : 16'h0000;
    ramp_duty = o_full_drive ? DUTY_FULL : i_loop_duty;
    if (ramp_len != 16'h0000 && since_comm < ramp_len)
      ramp_duty = 8'((32'(ramp_duty) * 32'(since_comm)) / 32'(ramp_len));
    else if (ramp_len != 16'h0000 && left < ramp_len)
      ramp_duty = 8'((32'(ramp_duty) * 32'(left)) / 32'(ramp_len));
  end

  // ------------------------------------------------------------
  // Lock detection and protection timing
  // ------------------------------------------------------------
  fsl_state_t  state;
  logic [31:0] idle_cnt;
  logic [31:0] prot_cnt;
  logic [2:0]  lock_runs;
  logic [2:0]  edges_seen;
  logic        stop_seen;
  logic        hold_remain;
  always_ff @(posedge i_clk) begin
    if (i_rst || hall_cross || state != FSL_RUN)
      idle_cnt <= 32'h0;
    else if (idle_cnt != 32'hffffffff)
      idle_cnt <= idle_cnt + 32'h1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state       <= FSL_STOPPED;
      prot_cnt    <= 32'h0;
      lock_runs   <= 3'h0;
      edges_seen  <= 3'h0;
      stop_seen   <= 1'b0;
      hold_remain <= 1'b0;
    end else begin
      case (state)
        FSL_STOPPED: begin
          edges_seen <= 3'h0;
          if (!stopped_low)
            state <= FSL_RUN;
        end
        FSL_RUN: begin
          if (hall_cross && edges_seen != RESTART_EDGES)
            edges_seen <= edges_seen + 3'h1;
          if (stopped_low) begin
            state <= FSL_STOPPED;
          end else if (idle_cnt > 32'(LOCK_DET)) begin
            state     <= FSL_LOCKED;
            prot_cnt  <= (lock_runs < LOCK_SHORT_RUNS) ? 32'(LOCK_SHORT_CYC)
                                                       : 32'(LOCK_LONG_CYC);
            lock_runs <= (lock_runs < LOCK_SHORT_RUNS) ? lock_runs + 3'h1 : 3'h0;
            stop_seen <= 1'b0;
          end else if (edges_seen == RESTART_EDGES) begin
            lock_runs <= 3'h0;
          end
        end
        FSL_LOCKED: begin
          edges_seen <= 3'h0;
          if (zero_duty)
            stop_seen <= 1'b1;
          if (stop_seen && i_pwm_edge) begin
            lock_runs <= 3'h0;
            state     <= FSL_STOPPED;
          end else if (prot_cnt != 32'h0) begin
            prot_cnt <= prot_cnt - 32'h1;
          end else begin
            state <= FSL_RESTART;
          end
        end
        FSL_RESTART: begin
          // Outputs are off here; a stop keeps the count but only sets hold_remain, so RUN follows next clock and a later visit waits for a PWM edge
          if (zero_duty)
            hold_remain <= 1'b1;
          if (hold_remain && i_pwm_edge) begin
            hold_remain <= 1'b0;
            state       <= FSL_RUN;
          end else if (!hold_remain) begin
            state <= FSL_RUN;
          end
        end
        default: state <= FSL_STOPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      o_lock_active <= 1'b0;
    else if (state == FSL_LOCKED)
      o_lock_active <= 1'b1;
    else if (state == FSL_RUN && edges_seen == RESTART_EDGES)
      o_lock_active <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      o_tach_pulse_out <= 1'b0;
    else
      o_tach_pulse_out <= i_tach_output_select ? o_lock_active : tach_toggle;
  end

  // ------------------------------------------------------------
  // Bridge drive and protections
  // ------------------------------------------------------------
  logic all_off;
  assign all_off = i_thermal_shutdown || state != FSL_RUN;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bridge_out_a    <= 1'b0;
      o_bridge_out_a_oe <= 1'b0;
      o_bridge_out_b    <= 1'b0;
      o_bridge_out_b_oe <= 1'b0;
      o_out_duty        <= 8'h00;
      o_recirculate     <= 1'b0;
    end else if (all_off) begin
      o_bridge_out_a_oe <= 1'b0;
      o_bridge_out_b_oe <= 1'b0;
      o_out_duty        <= 8'h00;
      o_recirculate     <= 1'b0;
    end else if (i_undervoltage_lockout) begin
      // Low drive sits opposite the high Hall input, high drive beside it
      o_bridge_out_a    <= i_drive_mode_select[1];
      o_bridge_out_b    <= i_drive_mode_select[1];
      o_bridge_out_a_oe <= (i_hall_input_a == i_drive_mode_select[1]);
      o_bridge_out_b_oe <= (i_hall_input_b == i_drive_mode_select[1]);
      o_out_duty        <= 8'h00;
      o_recirculate     <= 1'b1;
    end else begin
      o_bridge_out_a    <= i_hall_input_a;
      o_bridge_out_b    <= ~i_hall_input_a;
      o_bridge_out_a_oe <= 1'b1;
      o_bridge_out_b_oe <= 1'b1;
      o_out_duty        <= i_current_limiter ? 8'h00 : ramp_duty;
      o_recirculate     <= i_current_limiter;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_locked_wait;
    state == FSL_LOCKED && stop_seen && i_pwm_edge;
  endsequence

  a_thermal_all_off: assert property (@(posedge i_clk) disable iff (i_rst)
    i_thermal_shutdown |=> !o_bridge_out_a_oe && !o_bridge_out_b_oe)
    else $error("bridge driven during thermal shutdown");
  a_tach_toggles: assert property (@(posedge i_clk) disable iff (i_rst)
    hall_cross |=> tach_toggle != $past(tach_toggle))
    else $error("tach did not toggle on hall crossing");
  a_lock_entry: assert property (@(posedge i_clk) disable iff (i_rst)
    state == FSL_RUN && !stopped_low && idle_cnt > 32'(LOCK_DET) |=> state == FSL_LOCKED)
    else $error("lock not entered after idle time");
  a_lock_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
    state == FSL_LOCKED |=> o_lock_active)
    else $error("lock flag not raised");
  a_stop_zero_speed: assert property (@(posedge i_clk) disable iff (i_rst)
    zero_duty |=> ##1 o_target_speed == 8'h00)
    else $error("zero speed not commanded below threshold");
  a_code15_thresh: assert property (@(posedge i_clk) disable iff (i_rst)
    i_stop_select == STOP_USE_MIN |-> stop_thr == i_duty_min)
    else $error("code 15 threshold not minimum duty");
  a_counter_reset: assert property (@(posedge i_clk) disable iff (i_rst)
    s_locked_wait |=> lock_runs == 3'h0 && state == FSL_STOPPED)
    else $error("lock counter not reset by stop duty");
  a_undervoltage_lockout_recirc: assert property (@(posedge i_clk) disable iff (i_rst)
    !all_off && i_undervoltage_lockout |=> o_recirculate && o_out_duty == 8'h00)
    else $error("undervoltage did not recirculate");
endmodule

// ===== fsl_motor_model.sv
// Behavioural fan rotor with Hall sensor, moved by the bridge output enables
`timescale 1ns/10ps
module fsl_motor_model #(
  parameter int HALF = 40
) (
  input  wire logic i_clk,
  input  wire logic i_bridge_out_a_oe,
  input  wire logic i_bridge_out_b_oe,
  input  wire logic i_stall,
  output logic      o_hall_input_a,
  output logic      o_hall_input_b
);
  int cnt;
  initial begin
    cnt = 0;
    o_hall_input_a = 1'b0;
  end
  // Rotor turns only while a coil is driven; a stalled rotor holds its Hall level
  always @(posedge i_clk) begin
    if ((i_bridge_out_a_oe || i_bridge_out_b_oe) && !i_stall) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        o_hall_input_a <= ~o_hall_input_a;
      end
    end
  end
  assign o_hall_input_b = ~o_hall_input_a;
endmodule

// ===== tb.sv
// Self-checking testbench for the fan stop, soft-switch and lock controller
`timescale 1ns/10ps
module tb;
  localparam int DET   = 200;
  localparam int SHORT = 1000;
  localparam int LONG  = 4000;
  logic        i_clk, i_rst, pwm, fullo, tsel, stall, thermal_shutdown, uv, current_limiter;
  logic [7:0]  duty, dmin, dmax, smin, smax, pf, ps, lduty, thr, spd, oduty;
  logic [3:0]  sel, swf, sws;
  logic [1:0]  mode;
  logic [15:0] cper;
  logic        ha, hb, fdrv, oa, oa_oe, ob, ob_oe, recirc, tach, lock;
  logic [8:0]  ph;
  int          fail_count, checks_done, n;
  wire         drv = oa_oe | ob_oe;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  fsl_ctrl #(.LOCK_SHORT_CYC(SHORT), .LOCK_LONG_CYC(LONG), .LOCK_DET(DET)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_duty_in(duty), .i_pwm_edge(pwm),
    .i_duty_min(dmin), .i_duty_max(dmax), .i_speed_min(smin), .i_speed_max(smax),
    .i_stop_select(sel), .i_full_output(fullo), .i_softswitch_width_fast(swf),
    .i_softswitch_width_slow(sws), .i_phase_adjust_fast(pf), .i_phase_adjust_slow(ps),
    .i_loop_duty(lduty), .i_comm_period(cper), .i_tach_output_select(tsel),
    .i_drive_mode_select(mode), .i_hall_input_a(ha), .i_hall_input_b(hb),
    .i_thermal_shutdown(thermal_shutdown), .i_undervoltage_lockout(uv), .i_current_limiter(current_limiter),
    .o_target_speed(spd), .o_full_drive(fdrv), .o_phase_adjust(ph), .o_out_duty(oduty),
    .o_bridge_out_a(oa), .o_bridge_out_a_oe(oa_oe), .o_bridge_out_b(ob),
    .o_bridge_out_b_oe(ob_oe), .o_recirculate(recirc), .o_tach_pulse_out(tach),
    .o_lock_active(lock));
  fsl_motor_model #(.HALF(40)) i_motor (
    .i_clk(i_clk), .i_bridge_out_a_oe(oa_oe), .i_bridge_out_b_oe(ob_oe),
    .i_stall(stall), .o_hall_input_a(ha), .o_hall_input_b(hb));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Latencies inside the lock timer are not pinned down, so allow a small slack
  task automatic chk_near(input string nm, input int e, input int g, input int tol);
    checks_done++;
    if (g < e - tol || g > e + tol) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wait_drv(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (drv !== v && cnt < lim) begin
      tick(1);
      cnt++;
    end
    // A wait that runs out means the lock timer hung
    if (drv !== v) begin
      fail_count++;
      $display("ERROR wait_drv expected %b seen %b", v, drv);
    end
  endtask
  task automatic finish_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_stop();
    sel = 4'd0;
    duty = 8'd0;
    tick(4);
    chk("spd_code0", smin, spd);
    for (int c = 1; c <= 15; c++) begin
      sel = 4'(c);
      thr = (c == 15) ? dmin : 8'(5 * c);
      duty = thr;
      tick(4);
      chk("spd_at_stop", 16'h0, spd);
      duty = thr + 8'd4;
      tick(4);
      chk("spd_in_hyst", 16'h0, spd);
      duty = thr + 8'd5;
      tick(4);
      chk("spd_restart", (c == 15) ? 8'd55 : smin, spd);
    end
    dmin = 8'd20;
    dmax = 8'd120;
    sel = 4'd14;
    duty = 8'd20;
    tick(4);
    chk("spd_min_thr", 16'h0, spd);
    duty = 8'd24;
    tick(4);
    chk("spd_min_hyst", 16'h0, spd);
    duty = 8'd25;
    tick(4);
    chk("spd_min_thr_run", 16'h37, spd);
    dmin = 8'd100;
    dmax = 8'd200;
    $display("test stop done");
  endtask
  task automatic t_curve();
    sel = 4'd0;
    duty = 8'd150;
    tick(4);
    chk("spd_mid", 16'h64, spd);
    chk("phase_mid", 16'h0, ph);
    duty = 8'd255;
    tick(4);
    chk("spd_top", smax, spd);
    chk("phase_fast", 16'h005, ph);
    fullo = 1'b1;
    tick(4);
    chk("full_drive", 16'h1, fdrv);
    fullo = 1'b0;
    duty = 8'd100;
    tick(4);
    chk("phase_slow", 16'h1fb, ph);
    $display("test curve done");
  endtask
  task automatic t_wave();
    logic [7:0] lo, hi;
    int         hn, tn, rn;
    logic       ph_a, pt;
    duty = 8'd150;
    tsel = 1'b0;
    tick(100);
    lo = 8'hff;
    hi = 8'h00;
    hn = 0;
    tn = 0;
    rn = 0;
    ph_a = ha;
    pt = tach;
    repeat (400) begin
      tick(1);
      lo = (oduty < lo) ? oduty : lo;
      hi = (oduty > hi) ? oduty : hi;
      hn += int'(ha !== ph_a);
      tn += int'(tach !== pt);
      rn += int'(oduty < lduty);
      ph_a = ha;
      pt = tach;
    end
    chk("duty_floor", 16'h0, lo);
    chk("duty_peak", lduty, hi);
    chk("hall_moves", 16'h1, 16'(hn > 4));
    chk_near("tach_edges", hn, tn, 1);
    // Mid speed gives about 23 percent of a 40 cycle period on each side, ten periods
    chk_near("ramp_cycles", 180, rn, 15);
    $display("test wave done");
  endtask
  task automatic t_prot();
    logic [3:0] e;
    stall = 1'b1;
    thermal_shutdown = 1'b1;
    tick(3);
    chk("oe_thermal", 16'h0, {oa_oe, ob_oe});
    thermal_shutdown = 1'b0;
    tick(4);
    chk("oe_resume", 16'h1, drv);
    current_limiter = 1'b1;
    tick(3);
    chk("recirc", 16'h1, recirc);
    current_limiter = 1'b0;
    for (int p = 0; p < 2; p++) begin
      stall = 1'b0;
      tick(40);
      stall = 1'b1;
      uv = 1'b1;
      for (int m = 0; m < 4; m++) begin
        mode = 2'(m);
        tick(3);
        e = (m < 2) ? (ha ? 4'b0010 : 4'b1000) : (ha ? 4'b1100 : 4'b0011);
        chk("undervoltage_lockout_pins", e, {oa_oe, oa & oa_oe, ob_oe, ob & ob_oe});
      end
      uv = 1'b0;
    end
    stall = 1'b0;
    mode = 2'd0;
    tick(4);
    $display("test prot done");
  endtask
  task automatic t_lock();
    sel = 4'd1;
    duty = 8'd150;
    tsel = 1'b1;
    tick(100);
    chk("lockflag_run", 16'h0, tach);
    stall = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wait_drv(1'b0, DET + 100, n);
      if (i == 0) begin
        chk_near("lock_entry", DET - 15, n, 25);
        tick(1);
        chk("lockflag_set", 16'h1, tach);
      end
      chk("oe_lock", 16'h0, {oa_oe, ob_oe});
      wait_drv(1'b1, LONG + 500, n);
      chk_near("lock_period", (i < 4) ? SHORT : LONG, n, 4);
    end
    // Fill the counter up to its fifth slot, so a missed reset shows as a long wait
    for (int i = 0; i < 4; i++) begin
      wait_drv(1'b0, DET + 100, n);
      if (i < 3)
        wait_drv(1'b1, LONG + 500, n);
    end
    tick(50);
    duty = 8'd0;
    tick(5);
    pwm = 1'b1;
    tick(1);
    pwm = 1'b0;
    tick(5);
    duty = 8'd150;
    wait_drv(1'b1, LONG + 500, n);
    wait_drv(1'b0, DET + 100, n);
    wait_drv(1'b1, LONG + 500, n);
    chk_near("period_after_clear", SHORT, n, 4);
    stall = 1'b0;
    n = 0;
    while (tach !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    chk("lockflag_clear", 16'h0, tach);
    chk("lockflag_late", 16'h1, 16'(n > 100));
    $display("test lock done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {pwm, fullo, tsel, stall, thermal_shutdown, uv, current_limiter} = '0;
    duty = 8'h00;
    dmin = 8'h64;
    dmax = 8'hc8;
    smin = 8'h32;
    smax = 8'h96;
    pf = 8'h85;
    ps = 8'h05;
    lduty = 8'hc8;
    sel = 4'h0;
    swf = 4'hf;
    sws = 4'h0;
    mode = 2'h0;
    cper = 16'h0028;
    fail_count = 0;
    checks_done = 0;
    i_rst = 1'b1;
    tick(5);
    chk("reset_outputs", 16'h0, {spd, oa_oe, ob_oe, tach, lock, recirc});
    i_rst = 1'b0;
    t_stop();
    t_curve();
    t_wave();
    t_prot();
    t_lock();
    finish_test();
  end
  // Whole run needs roughly 15000 cycles; allow four times that
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    finish_test();
  end
endmodule
